// >>> dv/spc_top_tb.sv
// self-checking bench for the stop-mode power sequencer
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %s exp=%0h got=%0h", n, e, g); end end
module spc_top_tb;
  logic                          clk, rstn, stx, se, dbg, lde, ldse, ppd, leg, xrn, wp;
  logic                          wpo, wpv, rte, rtv, adca, irc, irs, erc, ers, hi, akw, akb, sup;
  logic [spc_pkg::PIN_COUNT-1:0] pin_i, pin_o;
  logic                          lat, flg, akr, core, ram, pclk, dclk, por, ill, ltf;
  logic                          adc, iref, rtc, reg_a, xo, in2, in3, s3;
  int                            failures, compares;
  // mode bits, then adc async, int ref en/stop, ext ref en/stop, high range
  localparam logic [10:0] TBL [6] = '{11'h07e, 11'h67f, 11'h5f7, 11'h50a, 11'h43e, 11'h57e};

  spc_top u_spc_top (
    .i_sys_clk(clk), .i_resetn(rstn), .i_stop_exec(stx), .i_stop_instr_enable(se),
    .i_debug_mode_enable(dbg), .i_lowvolt_detect_enable(lde),
    .i_lowvolt_detect_in_stop_enable(ldse), .i_partial_powerdown_ctrl(ppd),
    .i_legacy_mask(leg), .i_ext_resetn(xrn), .i_legacy_wake_pin(wp),
    .i_legacy_wake_pin_is_out(wpo), .i_legacy_wake_pin_out_val(wpv), .i_rtc_enable(rte),
    .i_rtc_event(rtv), .i_adc_async_clk_enable(adca), .i_int_refclk_enable(irc),
    .i_int_ref_stop_enable(irs), .i_ext_refclk_enable(erc), .i_ext_ref_stop_enable(ers),
    .i_osc_high_range(hi), .i_powerdown_ack_wr(akw), .i_powerdown_ack_bit(akb),
    .i_supply_below_low_trip(sup), .i_pin_ctrl(pin_i), .o_pin_ctrl(pin_o),
    .o_pin_latch_closed(lat), .o_stop2_recovery_flag(flg), .o_powerdown_ack_bit(akr),
    .o_core_power_on(core), .o_ram_array_power_on(ram), .o_periph_clk_en(pclk),
    .o_debug_clk_en(dclk), .o_por_reset(por), .o_illegal_op_reset(ill),
    .o_lowvolt_low_trip_force(ltf), .o_adc_run(adc), .o_int_ref_run(iref), .o_rtc_run(rtc),
    .o_regulator_active(reg_a), .o_crystal_osc_run(xo), .o_in_stop2(in2), .o_in_stop3(in3));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic stepn(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic go(input logic [4:0] m);
    {se, dbg, lde, ldse, ppd} = m;
    stx = 1'b1;
    @(negedge clk);
    stx = 1'b0;
  endtask

  // bounded waits: a hung sequencer shows as a failed compare, not a stall
  task automatic wait_run();
    int k;
    k = 0;
    while ((in2 | in3 | por | ill) !== 1'b0 && k < 60) begin
      @(negedge clk);
      k++;
    end
    `CHK("run", 1'b0, in2 | in3 | por);
  endtask

  task automatic wait_por();
    int k;
    k = 0;
    while (por !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    `CHK("por", 1'b1, por);
  endtask

  task automatic wake_ext();
    xrn = 1'b0;
    stepn(4);
    xrn = 1'b1;
    wait_run();
  endtask

  task automatic do_ack(input logic b);
    akw = 1'b1;
    akb = b;
    @(negedge clk);
    akw = 1'b0;
  endtask

  task automatic t_stop2();
    pin_i = 8'ha5;
    go(5'h11);
    `CHK("in2", 1'b1, in2);
    `CHK("core", 1'b0, core);
    `CHK("ram", 1'b1, ram);
    `CHK("pclk", 1'b0, pclk);
    `CHK("regulator", 1'b0, reg_a);
    `CHK("latch", 1'b1, lat);
    pin_i = 8'h3c;
    stepn(1);
    `CHK("pins held", 8'ha5, pin_o);
    sup = 1'b1;
    xrn = 1'b0;
    wait_por();
    xrn = 1'b1;
    `CHK("flag", 1'b1, flg);
    `CHK("low trip", 1'b1, ltf);
    stepn(8);
    `CHK("por held", 1'b1, por);
    sup = 1'b0;
    wait_run();
    `CHK("pins kept", 8'ha5, pin_o);
    do_ack(1'b0);
    stepn(1);
    `CHK("flag zero ack", 1'b1, flg);
    `CHK("ack reads", 1'b0, akr);
    do_ack(1'b1);
    `CHK("flag clr", 1'b0, flg);
    `CHK("latch open", 1'b0, lat);
    `CHK("pins live", 8'h3c, pin_o);
    `CHK("core on", 1'b1, core);
  endtask

  task automatic t_pin();
    go(5'h11);
    wp = 1'b0;
    stepn(6);
    `CHK("pin new mask", 1'b1, in2);
    {wp, leg, wpo, wpv} = 4'h7;
    wp = 1'b0;
    stepn(6);
    `CHK("pin out high", 1'b1, in2);
    wpo = 1'b0;
    wait_por();
    wp = 1'b1;
    `CHK("flag pin", 1'b1, flg);
    wait_run();
    do_ack(1'b1);
  endtask

  task automatic t_rtc();
    rte = 1'b0;
    go(5'h11);
    `CHK("rtc off", 1'b0, rtc);
    rtv = 1'b1;
    stepn(6);
    `CHK("rtc masked", 1'b1, in2);
    rtv = 1'b0;
    wake_ext();
    do_ack(1'b1);
    rte = 1'b1;
    go(5'h11);
    `CHK("rtc on", 1'b1, rtc);
    rtv = 1'b1;
    wait_por();
    rtv = 1'b0;
    wait_run();
    do_ack(1'b1);
  endtask

  task automatic t_modes();
    for (int i = 0; i < 6; i++) begin
      {adca, irc, irs, erc, ers, hi} = TBL[i][5:0];
      go(TBL[i][10:6]);
      s3 = se & (dbg | ldse | ~ppd);
      `CHK("illegal", ~se, ill);
      `CHK("stop3", s3, in3);
      `CHK("stop2", se & ~s3, in2);
      if (se) begin
        `CHK("pclk", 1'b0, pclk);
        `CHK("dclk", dbg, dclk);
        `CHK("adc", s3 & adca & lde, adc);
        `CHK("iref", s3 & irc & irs, iref);
        `CHK("crystal osc", s3 & erc & ers & (~hi | lde), xo);
        `CHK("regulator", s3 & ((lde & ldse) | dbg), reg_a);
        wake_ext();
        if (!s3) do_ack(1'b1);
      end else begin
        @(negedge clk);
        `CHK("ill pulse", 1'b0, ill);
      end
    end
  endtask

  initial begin
    #(50 * 6000);
    failures++;
    report_and_stop();
  end

  initial begin
    {rstn, stx, se, dbg, lde, ldse, ppd, leg, wpo, wpv, rte, rtv} = '0;
    {adca, irc, irs, erc, ers, hi, akw, akb, sup} = '0;
    {xrn, wp} = 2'h3;
    pin_i = '0;
    failures = 0;
    compares = 0;
    stepn(12);
    rstn = 1'b1;
    stepn(3);
    `CHK("flag rst", spc_pkg::RST_RECOVERY_FLAG, flg);
    `CHK("latch rst", spc_pkg::RST_PIN_LATCH, lat);
    t_stop2();
    t_pin();
    t_rtc();
    t_modes();
    report_and_stop();
  end
endmodule

// >>> rtl/spc_ctl_if.sv
// mode selection bundle between the stop-mode selector and the sequencer
`timescale 1ns/100ps
interface spc_ctl_if;
  logic sel_stop2;
  logic sel_stop3;
  logic sel_illegal;
  logic stop3_regulator_active;
  modport selector (output sel_stop2, output sel_stop3, output sel_illegal,
                    output stop3_regulator_active);
  modport sequencer (input sel_stop2, input sel_stop3, input sel_illegal,
                     input stop3_regulator_active);
endinterface

// >>> rtl/spc_mode_sel.sv
// stop mode selection from the enable bits
`timescale 1ns/100ps
module spc_mode_sel (
  input  wire logic i_stop_instr_enable,
  input  wire logic i_debug_mode_enable,
  input  wire logic i_lowvolt_detect_enable,
  input  wire logic i_lowvolt_detect_in_stop_enable,
  input  wire logic i_partial_powerdown_ctrl,
  spc_ctl_if.selector ctl
);
  logic detect_in_stop;
  assign detect_in_stop = i_lowvolt_detect_enable & i_lowvolt_detect_in_stop_enable;
  assign ctl.sel_illegal = ~i_stop_instr_enable;
  // debug or detector-in-stop demote a deep request to stop3
  assign ctl.sel_stop2 = i_stop_instr_enable & i_partial_powerdown_ctrl
                         & ~i_debug_mode_enable
                         & ~i_lowvolt_detect_in_stop_enable;
  assign ctl.sel_stop3 = i_stop_instr_enable & ~ctl.sel_stop2;
  assign ctl.stop3_regulator_active = detect_in_stop | i_debug_mode_enable;
endmodule

// >>> rtl/spc_pkg.sv
// constants and types shared by the stop-mode power controller
package spc_pkg;
  localparam logic       RST_RECOVERY_FLAG = 1'b0;
  localparam logic       RST_PIN_LATCH     = 1'b0;
  localparam int         WAKE_RESET_CYCLES = 4;
  localparam logic [2:0] WAKE_CNT_W_ONE    = 3'h1;
  localparam int         PIN_COUNT         = 8;
  localparam logic       LEGACY_MASK_DEF   = 1'b1;
  typedef enum logic [2:0] {
    SPC_RUN,
    SPC_STOP3,
    SPC_STOP2,
    SPC_WAKE_RST,
    SPC_ILLEGAL_RST
  } spc_state_t;
endpackage

// >>> rtl/spc_top.sv
// stop-mode power sequencer: entry, pin latching, wake and recovery
// Operation
// - stop2 powers down nearly everything except RAM array.
// - entering stop2 latches all pin control signals.
// - external reset wakes from stop2.
// - legacy masks: low level on shared wake pin also wakes.
// - legacy masks: wake pin ignored in stop2 while output driven high.
// - enabled real-time counter event wakes from stop2.
// - stop2 wake acts as power-on reset, reset vector fetched.
// - wake enables low-voltage reset with low trip point.
// - wake sets the stop2 recovery flag.
// - flag and pin latches hold until acknowledge bit written one.
// - software restores port registers before acknowledging.
// - software re-enables pin peripherals before acknowledging.
// - any stop mode gates off peripheral clocks, even with debug.
// - stop3 ADC runs only with async clock and detector enabled.
// - stop3 internal reference runs only with both enables set.
// - real-time counter runs in stop only when enabled.
// - stop3 regulator active with detector and detector-in-stop, or debug; stop2 off.
// - stop3 oscillator needs both enables, high range also detector.
// - debug enable turns a stop2 attempt into stop3.
// - detector-in-stop enable turns a stop2 attempt into stop3.
// - stop with enable clear resets; stop2 only per selection.
`timescale 1ns/100ps
module spc_top (
  input  wire logic i_sys_clk,
  input  wire logic i_resetn,
  input  wire logic i_stop_exec,
  input  wire logic i_stop_instr_enable,
  input  wire logic i_debug_mode_enable,
  input  wire logic i_lowvolt_detect_enable,
  input  wire logic i_lowvolt_detect_in_stop_enable,
  input  wire logic i_partial_powerdown_ctrl,
  input  wire logic i_legacy_mask,
  input  wire logic i_ext_resetn,
  input  wire logic i_legacy_wake_pin,
  input  wire logic i_legacy_wake_pin_is_out,
  input  wire logic i_legacy_wake_pin_out_val,
  input  wire logic i_rtc_enable,
  input  wire logic i_rtc_event,
  input  wire logic i_adc_async_clk_enable,
  input  wire logic i_int_refclk_enable,
  input  wire logic i_int_ref_stop_enable,
  input  wire logic i_ext_refclk_enable,
  input  wire logic i_ext_ref_stop_enable,
  input  wire logic i_osc_high_range,
  input  wire logic i_powerdown_ack_wr,
  input  wire logic i_powerdown_ack_bit,
  input  wire logic i_supply_below_low_trip,
  input  wire logic [spc_pkg::PIN_COUNT-1:0] i_pin_ctrl,
  output logic [spc_pkg::PIN_COUNT-1:0] o_pin_ctrl,
  output logic o_pin_latch_closed,
  output logic o_stop2_recovery_flag,
  output logic o_powerdown_ack_bit,
  output logic o_core_power_on,
  output logic o_ram_array_power_on,
  output logic o_periph_clk_en,
  output logic o_debug_clk_en,
  output logic o_por_reset,
  output logic o_illegal_op_reset,
  output logic o_lowvolt_low_trip_force,
  output logic o_adc_run,
  output logic o_int_ref_run,
  output logic o_rtc_run,
  output logic o_regulator_active,
  output logic o_crystal_osc_run,
  output logic o_in_stop2,
  output logic o_in_stop3
);
  spc_ctl_if ctl ();

  spc_mode_sel u_sel (
    .i_stop_instr_enable            (i_stop_instr_enable),
    .i_debug_mode_enable            (i_debug_mode_enable),
    .i_lowvolt_detect_enable        (i_lowvolt_detect_enable),
    .i_lowvolt_detect_in_stop_enable(i_lowvolt_detect_in_stop_enable),
    .i_partial_powerdown_ctrl       (i_partial_powerdown_ctrl),
    .ctl                            (ctl)
  );

  // wake inputs are asynchronous: two flops before use
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      sync1_q <= 3'h7;
      sync2_q <= 3'h7;
    end else begin
      sync1_q <= {i_ext_resetn, i_legacy_wake_pin, ~i_rtc_event};
      sync2_q <= sync1_q;
    end
  end
  logic ext_rst_n_s;
  logic wake_pin_s;
  logic rtc_evt_s;
  assign ext_rst_n_s = sync2_q[2];
  assign wake_pin_s  = sync2_q[1];
  assign rtc_evt_s   = ~sync2_q[0];

  logic wake_pin_armed;
  // a pin driven high as output cannot wake from stop2
  assign wake_pin_armed = i_legacy_mask
                          & ~(i_legacy_wake_pin_is_out & i_legacy_wake_pin_out_val);
  logic stop2_wake;
  assign stop2_wake = ~ext_rst_n_s
                      | (wake_pin_armed & ~wake_pin_s)
                      | (i_rtc_enable & rtc_evt_s);

  spc_pkg::spc_state_t state_q;
  spc_pkg::spc_state_t state_d;
  logic [2:0] wcnt_q;
  logic       ack_one;
  assign ack_one = i_powerdown_ack_wr & i_powerdown_ack_bit;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      spc_pkg::SPC_RUN: begin
        if (i_stop_exec && ctl.sel_illegal) begin
          state_d = spc_pkg::SPC_ILLEGAL_RST;
        end else if (i_stop_exec && ctl.sel_stop2) begin
          state_d = spc_pkg::SPC_STOP2;
        end else if (i_stop_exec && ctl.sel_stop3) begin
          state_d = spc_pkg::SPC_STOP3;
        end
      end
      spc_pkg::SPC_STOP3: begin
        if (!ext_rst_n_s || (i_rtc_enable && rtc_evt_s) || !wake_pin_s) begin
          state_d = spc_pkg::SPC_RUN;
        end
      end
      spc_pkg::SPC_STOP2: begin
        if (stop2_wake) begin
          state_d = spc_pkg::SPC_WAKE_RST;
        end
      end
      spc_pkg::SPC_WAKE_RST: begin
        // held in reset while supply sits below the low trip
        if (wcnt_q == spc_pkg::WAKE_CNT_W_ONE && !i_supply_below_low_trip) begin
          state_d = spc_pkg::SPC_RUN;
        end
      end
      spc_pkg::SPC_ILLEGAL_RST: begin
        state_d = spc_pkg::SPC_RUN;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      state_q <= spc_pkg::SPC_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      wcnt_q <= 3'h0;
    end else if (state_d == spc_pkg::SPC_WAKE_RST && state_q != spc_pkg::SPC_WAKE_RST) begin
      wcnt_q <= 3'(spc_pkg::WAKE_RESET_CYCLES);
    end else if (state_q == spc_pkg::SPC_WAKE_RST && wcnt_q > spc_pkg::WAKE_CNT_W_ONE) begin
      wcnt_q <= wcnt_q - 3'h1;
    end
  end

  // flag survives the wake reset; set beats the acknowledge clear
  logic flag_q;
  logic latch_q;
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      flag_q <= spc_pkg::RST_RECOVERY_FLAG;
    end else if (state_q == spc_pkg::SPC_STOP2 && stop2_wake) begin
      flag_q <= 1'b1;
    end else if (ack_one) begin
      flag_q <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      latch_q <= spc_pkg::RST_PIN_LATCH;
    end else if (state_d == spc_pkg::SPC_STOP2 && state_q == spc_pkg::SPC_RUN) begin
      latch_q <= 1'b1;
    end else if (ack_one && state_q == spc_pkg::SPC_RUN) begin
      latch_q <= 1'b0;
    end
  end

  // pin state captured at entry; on release pins follow live port/peripheral control
  logic [spc_pkg::PIN_COUNT-1:0] pin_hold_q;
  genvar gi;
  for (gi = 0; gi < spc_pkg::PIN_COUNT; gi++) begin : g_pin
    always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
        pin_hold_q[gi] <= 1'b0;
      end else if (!latch_q) begin
        pin_hold_q[gi] <= i_pin_ctrl[gi];
      end
    end
  end

  logic in_s2;
  logic in_s3;
  assign in_s2 = (state_q == spc_pkg::SPC_STOP2);
  assign in_s3 = (state_q == spc_pkg::SPC_STOP3);

  assign o_pin_ctrl            = latch_q ? pin_hold_q : i_pin_ctrl;
  assign o_pin_latch_closed    = latch_q;
  assign o_stop2_recovery_flag = flag_q;
  assign o_powerdown_ack_bit   = 1'b0;
  assign o_core_power_on       = ~in_s2;
  assign o_ram_array_power_on  = 1'b1;
  assign o_periph_clk_en       = ~(in_s2 | in_s3);
  assign o_debug_clk_en        = ~in_s2 & (~in_s3 | i_debug_mode_enable);
  assign o_por_reset           = (state_q == spc_pkg::SPC_WAKE_RST);
  assign o_illegal_op_reset    = (state_q == spc_pkg::SPC_ILLEGAL_RST);
  assign o_lowvolt_low_trip_force = (state_q == spc_pkg::SPC_WAKE_RST) | flag_q;
  assign o_adc_run = ~in_s2 & (~in_s3 | (i_adc_async_clk_enable & i_lowvolt_detect_enable));
  assign o_int_ref_run = ~in_s2 & (~in_s3 | (i_int_refclk_enable & i_int_ref_stop_enable));
  assign o_rtc_run = i_rtc_enable;
  assign o_regulator_active = ~in_s2 & (~in_s3 | ctl.stop3_regulator_active);
  assign o_crystal_osc_run = ~in_s2 & (~in_s3 | (i_ext_refclk_enable & i_ext_ref_stop_enable
                      & (~i_osc_high_range | i_lowvolt_detect_enable)));
  assign o_in_stop2 = in_s2;
  assign o_in_stop3 = in_s3;

  a_stop2_entry: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (state_q == spc_pkg::SPC_RUN && i_stop_exec && i_debug_mode_enable)
    |=> state_q != spc_pkg::SPC_STOP2) else $error("debug did not block stop2");
  a_detector_block: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (state_q == spc_pkg::SPC_RUN && i_stop_exec && i_lowvolt_detect_in_stop_enable)
    |=> state_q != spc_pkg::SPC_STOP2) else $error("detector did not block stop2");
  a_illegal_stop: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (state_q == spc_pkg::SPC_RUN && i_stop_exec && !i_stop_instr_enable)
    |=> o_illegal_op_reset ##1 !o_illegal_op_reset) else $error("no illegal reset");
  a_latch_entry: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    $rose(o_in_stop2) |-> o_pin_latch_closed) else $error("pins not latched");
  a_pin_held: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (o_pin_latch_closed && $past(o_pin_latch_closed)) |-> $stable(o_pin_ctrl))
    else $error("latched pins moved");
  a_flag_set: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (o_in_stop2 && stop2_wake) |=> o_stop2_recovery_flag && o_por_reset)
    else $error("wake did not set flag");
  a_flag_hold: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (o_stop2_recovery_flag && !ack_one) |=> o_stop2_recovery_flag)
    else $error("flag dropped without ack");
  a_ack_clear: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (ack_one && o_in_stop2 == 1'b0 && state_q == spc_pkg::SPC_RUN)
    |=> !o_stop2_recovery_flag && !o_pin_latch_closed) else $error("ack did not clear");
  a_wake_rst_len: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    $rose(o_por_reset) && !i_supply_below_low_trip |-> o_por_reset [*4] ##1 !o_por_reset)
    else $error("wake reset length wrong");
  a_clk_gate: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (o_in_stop2 || o_in_stop3) |-> !o_periph_clk_en) else $error("periph clock on in stop");
  a_s2_power: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    o_in_stop2 |-> !o_regulator_active && o_ram_array_power_on && !o_core_power_on)
    else $error("stop2 power wrong");
  a_s2_offs: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    o_in_stop2 |-> !o_adc_run && !o_int_ref_run && !o_crystal_osc_run && !o_debug_clk_en)
    else $error("stop2 module still on");
  a_run_power: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (!o_in_stop2 && !o_in_stop3) |-> o_periph_clk_en && o_core_power_on)
    else $error("run power wrong");

  // stop2 wake sources and stop3 external reset exit, seen one cycle after the synchronised event
  a_ext_wake: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (o_in_stop2 && !ext_rst_n_s) |=> o_por_reset)
    else $error("external reset did not wake");
  a_stop3_wake: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (o_in_stop3 && !ext_rst_n_s) |=> !o_in_stop3)
    else $error("external reset did not end stop3");
  a_pin_wake: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (o_in_stop2 && wake_pin_armed && !wake_pin_s) |=> o_por_reset)
    else $error("wake pin did not wake");
  a_pin_out_high: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (o_in_stop2 && i_legacy_wake_pin_is_out && i_legacy_wake_pin_out_val && ext_rst_n_s
     && !(i_rtc_enable && rtc_evt_s)) |=> o_in_stop2)
    else $error("driven high pin woke");
  a_rtc_wake: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (o_in_stop2 && i_rtc_enable && rtc_evt_s) |=> o_por_reset)
    else $error("counter event did not wake");
  a_rtc_masked: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (o_in_stop2 && !i_rtc_enable && ext_rst_n_s && (!wake_pin_armed || wake_pin_s))
    |=> o_in_stop2) else $error("disabled counter woke");

  // wake reset and recovery
  a_low_trip: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    o_por_reset |-> o_lowvolt_low_trip_force)
    else $error("low trip not forced");
  a_supply_hold: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (o_por_reset && i_supply_below_low_trip) |=> o_por_reset)
    else $error("left reset with low supply");
  a_flag_on_wake: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    $rose(o_stop2_recovery_flag) |-> o_por_reset)
    else $error("flag set without wake");
  a_wake_latched: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    o_por_reset |-> o_pin_latch_closed)
    else $error("latch open in wake reset");
  a_latch_open_ack: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    $fell(o_pin_latch_closed) |-> $past(ack_one))
    else $error("latch opened without ack");

  // stop3 module run enables; all of these default to standby
  a_debug_clk: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    o_in_stop3 |-> o_debug_clk_en == i_debug_mode_enable)
    else $error("debug clock wrong in stop3");
  a_adc_stop3: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    o_in_stop3 |-> o_adc_run == (i_adc_async_clk_enable && i_lowvolt_detect_enable))
    else $error("converter run wrong");
  a_int_ref_stop3: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    o_in_stop3 |-> o_int_ref_run == (i_int_refclk_enable && i_int_ref_stop_enable))
    else $error("internal reference run wrong");
  a_rtc_run: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (o_in_stop2 || o_in_stop3) |-> o_rtc_run == i_rtc_enable)
    else $error("counter run wrong");
  a_reg_stop3: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    o_in_stop3 |-> o_regulator_active == ((i_lowvolt_detect_enable
    && i_lowvolt_detect_in_stop_enable) || i_debug_mode_enable))
    else $error("stop3 regulator wrong");
  a_osc_stop3: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    o_in_stop3 |-> o_crystal_osc_run == (i_ext_refclk_enable && i_ext_ref_stop_enable
    && (!i_osc_high_range || i_lowvolt_detect_enable)))
    else $error("oscillator run wrong");

  // selection table, checked on the outputs rather than the selector
  a_stop2_select: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (state_q == spc_pkg::SPC_RUN && i_stop_exec && i_stop_instr_enable
     && i_partial_powerdown_ctrl && !i_debug_mode_enable
     && !i_lowvolt_detect_in_stop_enable) |=> o_in_stop2)
    else $error("stop2 not entered");
  a_stop3_select: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (state_q == spc_pkg::SPC_RUN && i_stop_exec && i_stop_instr_enable
     && !i_partial_powerdown_ctrl) |=> o_in_stop3)
    else $error("stop3 not entered");
  a_illegal_back: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    o_illegal_op_reset |=> !o_in_stop2 && !o_in_stop3)
    else $error("stop after illegal reset");

  c_stop2_wake: cover property (@(posedge i_sys_clk) o_in_stop2 ##1 o_por_reset);
  c_stop3: cover property (@(posedge i_sys_clk) $rose(o_in_stop3));
  c_ack: cover property (@(posedge i_sys_clk) o_stop2_recovery_flag ##1 !o_stop2_recovery_flag);
  c_illegal: cover property (@(posedge i_sys_clk) o_illegal_op_reset);
  c_low_supply: cover property (@(posedge i_sys_clk) o_por_reset && i_supply_below_low_trip);
endmodule
